// ==== rtl/rate_port_pkg.sv ====
// shared constants for the rate sensor serial port and its host
`default_nettype none
package rate_port_pkg;
  localparam int          FRAME_BITS     = 16;
  localparam int          CNT_W          = 5;
  localparam logic [4:0]  HOLD_END_EDGE  = 5'h0e;
  localparam logic [4:0]  LAST_EDGE      = 5'h10;
  localparam int          CFG_FLAG_BIT   = 15;
  localparam int          SRC_HI_BIT     = 11;
  localparam int          SRC_LO_BIT     = 10;
  localparam int          CODE_BIT       = 4;
  localparam logic [15:0] CMD_FIXED_MASK = 16'h4320;
  localparam logic [15:0] CMD_FIXED_VAL  = 16'h0300;
  localparam logic [1:0]  SRC_RATE       = 2'h0;
  localparam logic [1:0]  SRC_TEMP       = 2'h1;
  localparam logic [1:0]  SRC_AUX1       = 2'h2;
  localparam logic [1:0]  SRC_AUX2       = 2'h3;
  localparam logic [11:0] ST_SHIFT       = 12'h21c;
  localparam logic [11:0] OFFSET_HALF    = 12'h800;
  localparam logic [2:0]  CTRL_RESET     = 3'h0;
  localparam int          SCLK_HALF_DIV  = 4;
  localparam int          DIV_W          = 3;
  localparam int          CS_QUIET_CYC   = 2;
endpackage
`default_nettype wire

// ==== rtl/rate_link_if.sv ====
// serial link between host master and rate sensor port
`default_nettype none
interface rate_link_if;
  logic chip_sel_n;
  logic sclk;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  wire  serial_out_line = serial_out_oe ? serial_out : 1'b1;
  modport device (input chip_sel_n, sclk, serial_in, output serial_out, serial_out_oe);
  modport host   (output chip_sel_n, sclk, serial_in, input serial_out, serial_out_oe, serial_out_line);
endinterface
`default_nettype wire

// ==== rtl/rate_sensor_serial_port.sv ====
// device end: serial port, control register and conversion sequencing
// Overview of operation
// - chip select high: output off, inputs ignored
// - sixteen clocks per full duplex frame
// - host first bit: 1 configure, 0 read
// - first bit 0 keeps control register
// - input bits captured on clock falling edge
// - commit control word after sixteenth edge
// - short frame discards partial control word
// - select fall: drive output, hold, sample
// - fourteenth falling edge returns to track
// - falling edges step conversion, sixteen needed
// - short frame abandons conversion, output unchanged
// - host drives fixed bits at exact value
// - self test shifts rate output by 540 codes
// - both self tests together are harmless
// - two zeros, source, twelve data, then off
// - host command bit layout with fixed bits
// - source select and output coding bits
// - host uses polarity 1, phase 0
`default_nettype none
module rate_sensor_serial_port (
  input  wire logic        clk_in,          // system clock
  input  wire logic        rst_in,          // sync reset, high
  rate_link_if.device      link,            // serial link pins
  input  wire logic [11:0] rate_sample_in,  // rate sample, twos complement
  input  wire logic [11:0] temp_sample_in,  // temperature sample
  input  wire logic [11:0] aux1_sample_in,  // external input one
  input  wire logic [11:0] aux2_sample_in,  // external input two
  input  wire logic        self_test_neg_in,// negative self test
  input  wire logic        self_test_pos_in,// positive self test
  output logic [1:0]       source_select_out, // held source setting
  output logic             offset_code_out, // held coding setting
  output logic             tracking_out     // track-and-hold in track
);
  // two-flop synchronisers for link pins
  logic [1:0] cs_sync;
  logic [1:0] ck_sync;
  logic [1:0] di_sync;
  logic       cs_q;
  logic       ck_q;
  logic       st_n_q;
  logic       st_p_q;
  logic       st_n_s;
  logic       st_p_s;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cs_sync <= 2'h3;
      ck_sync <= 2'h3;
      di_sync <= 2'h0;
      cs_q    <= 1'b1;
      ck_q    <= 1'b1;
      st_n_q  <= 1'b0;
      st_p_q  <= 1'b0;
      st_n_s  <= 1'b0;
      st_p_s  <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[0], link.chip_sel_n};
      ck_sync <= {ck_sync[0], link.sclk};
      di_sync <= {di_sync[0], link.serial_in};
      cs_q    <= cs_sync[1];
      ck_q    <= ck_sync[1];
      st_n_q  <= self_test_neg_in;
      st_p_q  <= self_test_pos_in;
      st_n_s  <= st_n_q;
      st_p_s  <= st_p_q;
    end
  end

  // edge detection on synchronised pins
  wire cs_level = cs_sync[1];
  wire cs_fall  = cs_q & ~cs_level;
  wire ck_fall  = ck_q & ~ck_sync[1] & ~cs_level;
  wire in_bit   = di_sync[1];

  // frame state
  logic [rate_port_pkg::CNT_W-1:0] edge_cnt;
  logic [15:0]                     rx_shift;
  logic [15:0]                     tx_shift;
  logic [11:0]                     held_sample;
  logic [11:0]                     out_word;
  logic [1:0]                      held_src;
  logic [1:0]                      out_src;
  logic                            drive;
  logic                            hold;
  logic [2:0]                      ctrl;

  // selected sample with self test offsets
  logic [11:0] raw_sel;
  always_comb begin
    unique case (ctrl[2:1])
      rate_port_pkg::SRC_RATE: raw_sel = rate_sample_in;
      rate_port_pkg::SRC_TEMP: raw_sel = temp_sample_in;
      rate_port_pkg::SRC_AUX1: raw_sel = aux1_sample_in;
      rate_port_pkg::SRC_AUX2: raw_sel = aux2_sample_in;
    endcase
  end
  wire        is_rate    = (ctrl[2:1] == rate_port_pkg::SRC_RATE);
  wire [11:0] st_minus   = (is_rate & st_n_s) ? rate_port_pkg::ST_SHIFT : 12'h000;
  wire [11:0] st_plus    = (is_rate & st_p_s) ? rate_port_pkg::ST_SHIFT : 12'h000;
  // both shifts applied together net out; wraps modulo twelve bits
  wire [11:0] tested     = raw_sel - st_minus + st_plus;
  wire [11:0] coded      = ctrl[0] ? (tested ^ rate_port_pkg::OFFSET_HALF) : tested;

  // frame word: zero, zero, source, twelve data bits
  wire [15:0] frame_word = {2'h0, out_src, out_word};
  wire        last_edge  = ck_fall & (edge_cnt == rate_port_pkg::LAST_EDGE - 5'h01);
  wire        hold_end   = ck_fall & (edge_cnt == rate_port_pkg::HOLD_END_EDGE - 5'h01);
  wire        cfg_frame  = rx_shift[14];   // first bit after fourteen more shifts
  wire [15:0] rx_full    = {rx_shift[14:0], in_bit};

  // edge counter, cleared whenever select is high
  always_ff @(posedge clk_in) begin
    if (rst_in || cs_level) begin
      edge_cnt <= '0;
    end else if (ck_fall && edge_cnt != rate_port_pkg::LAST_EDGE) begin
      edge_cnt <= edge_cnt + 5'h01;
    end
  end

  // receive shift register on falling edges
  always_ff @(posedge clk_in) begin
    if (rst_in || cs_fall) begin
      rx_shift <= 16'h0000;
    end else if (ck_fall && edge_cnt != rate_port_pkg::LAST_EDGE) begin
      rx_shift <= rx_full;
    end
  end

  // control register commit only on full configuration frames
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl <= rate_port_pkg::CTRL_RESET;
    end else if (last_edge && cfg_frame) begin
      ctrl <= {rx_full[rate_port_pkg::SRC_HI_BIT], rx_full[rate_port_pkg::SRC_LO_BIT],
               rx_full[rate_port_pkg::CODE_BIT]};
    end
  end

  // track-and-hold: sample on select fall, track on fourteenth edge
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hold        <= 1'b0;
      held_sample <= 12'h000;
      held_src    <= rate_port_pkg::SRC_RATE;
    end else if (cs_fall) begin
      hold        <= 1'b1;
      held_sample <= coded;
      held_src    <= ctrl[2:1];
    end else if (hold_end) begin
      hold        <= 1'b0;
    end
  end

  // conversion result and its source kept only when all sixteen edges arrive
  // source travels with the data so a cut frame cannot pair new source, old data
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      out_word <= 12'h000;
      out_src  <= rate_port_pkg::SRC_RATE;
    end else if (last_edge) begin
      out_word <= held_sample;
      out_src  <= held_src;
    end
  end

  // transmit: drive from select fall, shift on falling edges
  always_ff @(posedge clk_in) begin
    if (rst_in || cs_level) begin
      drive    <= 1'b0;
      tx_shift <= 16'h0000;
    end else if (cs_fall) begin
      drive    <= 1'b1;
      tx_shift <= frame_word;
    end else if (last_edge) begin
      drive    <= 1'b0;
    end else if (ck_fall) begin
      tx_shift <= {tx_shift[14:0], 1'b0};
    end
  end

  assign link.serial_out    = tx_shift[15];
  assign link.serial_out_oe = drive;
  assign source_select_out  = ctrl[2:1];
  assign offset_code_out    = ctrl[0];
  assign tracking_out       = ~hold;
endmodule // rate_sensor_serial_port
`default_nettype wire

// ==== rtl/rate_host_master.sv ====
// host end: APB-controlled serial master for the rate sensor port
`default_nettype none
module rate_host_master (
  input  wire logic        clk_in,      // system clock
  input  wire logic        rst_in,      // sync reset, high
  rate_link_if.host        link,        // serial link pins
  input  wire logic        psel_in,     // apb select
  input  wire logic        penable_in,  // apb enable
  input  wire logic        pwrite_in,   // apb direction
  input  wire logic [11:0] paddr_in,    // apb byte address
  input  wire logic [31:0] pwdata_in,   // apb write data
  output logic [31:0]      prdata_out,  // apb read data
  output logic             pready_out,  // apb ready
  output logic             pslverr_out  // apb error
);
  localparam logic [11:0] ADDR_CMD    = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_RESULT = 12'h008;

  typedef enum {IDLE, SETUP, LOW, HIGH, QUIET} host_state_t;
  host_state_t state;

  logic [15:0]                     cmd;
  logic [15:0]                     tx;
  logic [15:0]                     rx;
  logic [15:0]                     result;
  logic [rate_port_pkg::CNT_W-1:0] bits;
  logic [rate_port_pkg::DIV_W-1:0] div;
  logic                            start;
  logic                            done;
  logic [1:0]                      so_sync;
  logic [31:0]                     rdata;

  // apb decode
  wire wr_access = psel_in & penable_in & pwrite_in;
  wire busy      = (state != IDLE);
  wire hit_cmd   = (paddr_in == ADDR_CMD);
  wire hit_stat  = (paddr_in == ADDR_STATUS);
  wire hit_res   = (paddr_in == ADDR_RESULT);
  wire tick      = (div == rate_port_pkg::DIV_W'(rate_port_pkg::SCLK_HALF_DIV - 1));
  // fixed bits forced to their required values
  wire [15:0] cmd_word = (pwdata_in[15:0] & ~rate_port_pkg::CMD_FIXED_MASK) | rate_port_pkg::CMD_FIXED_VAL;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~(hit_cmd | hit_stat | hit_res);
  assign rdata       = hit_res  ? {16'h0000, result} :
                       hit_stat ? {30'h0, done, busy} :
                       hit_cmd  ? {16'h0000, cmd} : 32'h0;

  // registers and read data
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cmd        <= rate_port_pkg::CMD_FIXED_VAL;
      start      <= 1'b0;
      prdata_out <= 32'h0;
    end else begin
      start      <= wr_access & hit_cmd & ~busy;
      prdata_out <= (psel_in & ~penable_in & ~pwrite_in) ? rdata : prdata_out;
      if (wr_access && hit_cmd && !busy) begin
        cmd <= cmd_word;
      end
    end
  end

  // sync of returned data pin
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      so_sync <= 2'h0;
    end else begin
      so_sync <= {so_sync[0], link.serial_out_line};
    end
  end

  // clock divider, one tick per half period
  always_ff @(posedge clk_in) begin
    if (rst_in || state == IDLE) begin
      div <= '0;
    end else begin
      div <= tick ? '0 : div + 1'b1;
    end
  end

  // frame sequencer: clock idles high, data changes on rising edge
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state           <= IDLE;
      link.chip_sel_n <= 1'b1;
      link.sclk       <= 1'b1;
      link.serial_in  <= 1'b0;
      tx              <= 16'h0;
      rx              <= 16'h0;
      result          <= 16'h0;
      bits            <= '0;
      done            <= 1'b0;
    end else begin
      if (wr_access && hit_stat && pwdata_in[1]) begin
        done <= 1'b0;
      end
      unique case (state)
        IDLE: if (start) begin
          state           <= SETUP;
          link.chip_sel_n <= 1'b0;
          link.serial_in  <= cmd[15];
          tx              <= {cmd[14:0], 1'b0};
          bits            <= '0;
        end
        SETUP: if (tick) begin
          state     <= LOW;
          link.sclk <= 1'b0;
        end
        LOW: if (tick) begin
          link.sclk <= 1'b1;
          rx        <= {rx[14:0], so_sync[1]};
          bits      <= bits + 1'b1;
          if (bits == rate_port_pkg::LAST_EDGE - 5'h01) begin
            state <= QUIET;
          end else begin
            state          <= HIGH;
            link.serial_in <= tx[15];
            tx             <= {tx[14:0], 1'b0};
          end
        end
        HIGH: if (tick) begin
          state     <= LOW;
          link.sclk <= 1'b0;
        end
        QUIET: if (tick) begin
          state           <= IDLE;
          link.chip_sel_n <= 1'b1;
          result          <= rx;
          done            <= 1'b1;
        end
      endcase
    end
  end
endmodule // rate_host_master
`default_nettype wire

// ==== bench/rate_link_checker.sv ====
// assertions on the serial link between host master and sensor port
`default_nettype none
module rate_link_checker (
  input wire logic clk_in,        // system clock
  input wire logic rst_in,        // sync reset
  input wire logic chip_sel_n,    // frame select
  input wire logic sclk,          // serial clock
  input wire logic serial_in,     // host to device
  input wire logic serial_out,    // device to host
  input wire logic serial_out_oe  // device drives line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] fall_cnt;
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // falling clock edges seen in this frame
  always_ff @(posedge clk_in) begin
    if (rst_in || chip_sel_n) fall_cnt <= 5'h00;
    else if ($fell(sclk)) fall_cnt <= fall_cnt + 5'h01;
  end
  idle_off_a: assert property (chip_sel_n [*4] |-> !serial_out_oe)
    else $error("output driven while deselected");
  out_enable_a: assert property ($fell(chip_sel_n) |-> ##[1:4] serial_out_oe)
    else $error("output not enabled after select");
  first_zero_a: assert property ($rose(serial_out_oe) |-> !serial_out)
    else $error("first output bit not zero");
  second_zero_a: assert property ($fell(sclk) && fall_cnt == 5'h00 |-> ##4 (serial_out_oe && !serial_out))
    else $error("second output bit not zero");
  release_out_a: assert property ($fell(sclk) && fall_cnt == 5'h0f |-> ##[1:4] !serial_out_oe)
    else $error("output not released after last edge");
  shift_stable_a: assert property ($rose(sclk) && serial_out_oe |=> $stable(serial_out) [*3])
    else $error("output moved while clock high");
  frame_count_a: assert property ($rose(chip_sel_n) |-> fall_cnt == 5'h10)
    else $error("frame without sixteen edges");
  idle_high_a: assert property (chip_sel_n |-> sclk)
    else $error("clock low while idle");
  din_stable_a: assert property ($fell(sclk) |-> $stable(serial_in))
    else $error("input moved at falling edge");
endmodule // rate_link_checker
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench: host master and sensor port joined over the link
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in, rst_in, psel, penable, pwrite, pready, pslverr;
  logic        st_neg, st_pos, code, trk, sclk_q;
  logic [11:0] paddr, rate_s, temp_s, aux1_s, aux2_s;
  logic [31:0] pwdata, prdata;
  logic [1:0]  src, src2;
  int          n_mismatch = 0, num_checks = 0, cyc = 0, nfall = 0;
  rate_link_if link ();
  rate_link_if link2 ();
  // both ends, plus a lone port driven by the bench
  rate_host_master i_rate_host_master (.clk_in(clk_in), .rst_in(rst_in), .link(link), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr));
  rate_sensor_serial_port i_rate_sensor_serial_port (.clk_in(clk_in), .rst_in(rst_in), .link(link),
    .rate_sample_in(rate_s), .temp_sample_in(temp_s), .aux1_sample_in(aux1_s), .aux2_sample_in(aux2_s),
    .self_test_neg_in(st_neg), .self_test_pos_in(st_pos), .source_select_out(src),
    .offset_code_out(code), .tracking_out(trk));
  rate_sensor_serial_port i_rate_sensor_serial_port_b (.clk_in(clk_in), .rst_in(rst_in), .link(link2),
    .rate_sample_in(rate_s), .temp_sample_in(temp_s), .aux1_sample_in(aux1_s), .aux2_sample_in(aux2_s),
    .self_test_neg_in(st_neg), .self_test_pos_in(st_pos), .source_select_out(src2),
    .offset_code_out(), .tracking_out());
  rate_link_checker chk_link (.clk_in(clk_in), .rst_in(rst_in), .chip_sel_n(link.chip_sel_n),
    .sclk(link.sclk), .serial_in(link.serial_in), .serial_out(link.serial_out),
    .serial_out_oe(link.serial_out_oe));
  // clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // track-and-hold watch at host sampling edges, and run limit
  always @(posedge clk_in) begin
    sclk_q <= link.sclk;
    cyc <= cyc + 1;
    if (link.chip_sel_n) nfall <= 0;
    else if (sclk_q && !link.sclk) nfall <= nfall + 1;
    if (!link.chip_sel_n && !sclk_q && link.sclk) chk("tracking", {31'h0, nfall >= 14}, {31'h0, trk});
    if (cyc == 30000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // one apb transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask
  // start a frame, wait for done, fetch result, clear done
  task automatic run(input logic [15:0] cmd, output logic [15:0] res);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, 12'h000, {16'h0000, cmd}, rd, er);
    rd = 32'h0;
    while (rd[1] !== 1'b1) apb(1'b0, 12'h004, 32'h0, rd, er);
    apb(1'b0, 12'h008, 32'h0, rd, er);
    res = rd[15:0];
    apb(1'b1, 12'h004, 32'h2, rd, er);
  endtask
  function automatic logic [15:0] exp_word(input logic [1:0] s, input logic c);
    logic [11:0] d;
    d = (s == 2'h0) ? rate_s : (s == 2'h1) ? temp_s : (s == 2'h2) ? aux1_s : aux2_s;
    if (s == 2'h0) d = d + (st_pos ? rate_port_pkg::ST_SHIFT : 12'h000) - (st_neg ? rate_port_pkg::ST_SHIFT : 12'h000);
    if (c) d = d ^ rate_port_pkg::OFFSET_HALF;
    return {2'b00, s, d};
  endfunction
  // bench-driven frame on the second link, nf falling edges
  task automatic bb_frame(input logic [15:0] w, input int nf, output logic [15:0] got);
    got = 16'h0000;
    link2.chip_sel_n <= 1'b0;
    link2.serial_in <= w[15];
    repeat (4) @(posedge clk_in);
    for (int i = 0; i < nf; i++) begin
      got = {got[14:0], link2.serial_out_line};
      link2.sclk <= 1'b0;
      repeat (4) @(posedge clk_in);
      link2.sclk <= 1'b1;
      link2.serial_in <= (i < 15) ? w[14-i] : 1'b0;
      repeat (4) @(posedge clk_in);
    end
    link2.chip_sel_n <= 1'b1;
    link2.serial_in <= ~link2.serial_in;
    repeat (8) @(posedge clk_in);
  endtask
  task automatic t_sources;
    logic [15:0] r;
    logic [1:0]  s;
    logic        c;
    for (int i = 0; i < 8; i++) begin
      s = i[2:1];
      c = i[0];
      run({4'h8, s, 2'h3, 3'h0, c, 4'h0}, r);
      chk("source", {30'h0, s}, {30'h0, src});
      chk("coding", {31'h0, c}, {31'h0, code});
      run(16'h0300, r);
      run(16'h0300, r);
      chk("word", {16'h0, exp_word(s, c)}, {16'h0, r});
    end
    run(16'h0400, r);
    chk("kept source", 32'h3, {30'h0, src});
    run(16'h0000, r);
    chk("kept word", {16'h0, exp_word(2'h3, 1'b1)}, {16'h0, r});
    $display("test sources done");
  endtask
  task automatic t_selftest;
    logic [15:0] r;
    run(16'h8300, r);
    for (int k = 0; k < 4; k++) begin
      st_neg <= k[0];
      st_pos <= k[1];
      run(16'h0300, r);
      run(16'h0300, r);
      chk("self test word", {16'h0, exp_word(2'h0, 1'b0)}, {16'h0, r});
    end
    $display("test self test done");
  endtask
  task automatic t_bus;
    logic [31:0] rd;
    logic        er;
    logic [15:0] r;
    apb(1'b0, 12'h00c, 32'h0, rd, er);
    chk("unmapped error", 32'h1, {31'h0, er});
    // fixed bits written wrong on purpose; host must force them
    apb(1'b1, 12'h000, 32'hc420, rd, er);
    run(16'h8b00, r);
    chk("busy write dropped", 32'h1, {30'h0, src});
    apb(1'b0, 12'h000, 32'h0, rd, er);
    chk("command word", 32'h8700, rd);
    $display("test bus done");
  endtask
  task automatic t_short;
    logic [15:0] g;
    aux1_s <= 12'h5a5;
    bb_frame(16'h8b00, 16, g);
    bb_frame(16'h0300, 16, g);
    aux1_s <= 12'h3c3;
    bb_frame(16'h8f00, 8, g);
    chk("short frame source", 32'h2, {30'h0, src2});
    bb_frame(16'h0300, 16, g);
    chk("after short frame", {16'h0, 4'h2, 12'h5a5}, {16'h0, g});
    $display("test short frame done");
  endtask
  // main sequence
  initial begin
    {psel, penable, pwrite, st_neg, st_pos} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    {rate_s, temp_s, aux1_s, aux2_s} = {12'h123, 12'h456, 12'h789, 12'habc};
    {link2.chip_sel_n, link2.sclk, link2.serial_in} = 3'h6;
    rst_in = 1'b1;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    chk("reset state", 32'h1, {28'h0, src, code, trk});
    chk("reset output off", 32'h0, {31'h0, link.serial_out_oe});
    $display("test reset done");
    t_sources();
    t_selftest();
    t_bus();
    t_short();
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
